// ---- design/uerm_mover.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - N bytes copied within N plus five cycles
// - Processor stalled during copy, resumes after
// - Control bits 6..4 select endpoint buffer
// - Error when count exceeds endpoint buffer size
// - Zero count or endpoint above four flagged
// - Good launch clears error; software may clear
// - Error when range leaves 0x100..0x10ff window
// - Range error raises security interrupt; registers kept
// - Error flag with enable asserts USB interrupt
// - Direction zero receives, one transmits
// - Written buffer data never read back
// - Software sets run bit, hardware clears it
// - Interrupts held off until copy ends
// - Fourteen-bit address, upper two bits zero
// - Address resets to 0x0100
// - Address is transmit source, receive destination
// - Address ends at last byte plus one
// - Registers inaccessible while USB disabled
// - Seven-bit count, bit seven reads zero
// - Count kept after copy completes
module uerm_mover #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic usb_enable,
	input wire logic usb_int_enable,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic cpu_stall,
	output logic irq_hold,
	output logic usb_irq,
	output logic security_irq,
	output logic ram_rd,
	output logic ram_wr,
	output logic [13:0] ram_addr,
	output logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata,
	output logic ep_rd,
	output logic ep_wr,
	output logic [2:0] ep_sel,
	output logic [7:0] ep_ptr,
	output logic [7:0] ep_wdata,
	input wire logic [7:0] ep_rdata
);
	initial
	begin
		if (FIFO_DEPTH < 2)
			$error("FIFO depth too small");
	end
	typedef struct packed {
		uerm_pkg::uerm_state_e state;
		logic [2:0] eps;
		logic err;
		logic dir;
		logic run;
		logic [13:0] addr;
		logic [6:0] count;
		logic [6:0] rd_left;
		logic [7:0] rd_ptr;
		logic [13:0] wr_addr;
		logic [7:0] wr_ptr;
		logic [7:0] move_cyc;
		logic src_pend;
		logic [7:0] rdata;
		logic cpu_stall;
		logic irq_hold;
		logic usb_irq;
		logic security_irq;
		logic ram_rd;
		logic ram_wr;
		logic [13:0] ram_addr;
		logic [7:0] ram_wdata;
		logic ep_rd;
		logic ep_wr;
		logic [7:0] ep_ptr;
		logic [7:0] ep_wdata;
	} uerm_mover_s;
	uerm_mover_s st_reg;
	uerm_mover_s st_next;
	logic [7:0] ep_size;
	logic [14:0] range_end;
	logic range_bad;
	logic launch_bad;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_pop;
	logic fifo_flush;
	logic src_valid;
	logic [7:0] src_data;
	logic acc_en;
	always_comb
	begin
		unique case (st_reg.eps)
			3'h0: ep_size = uerm_pkg::SIZE_EP0;
			3'h1, 3'h2, 3'h3: ep_size = uerm_pkg::SIZE_EP13;
			default: ep_size = uerm_pkg::SIZE_EP47;
		endcase
	end
	assign range_end = {1'b0, st_reg.addr} + {8'h00, st_reg.count} - 15'h0001;
	assign range_bad = st_reg.addr < uerm_pkg::WIN_LOW || range_end > uerm_pkg::WIN_END;
	assign launch_bad = range_bad || {1'b0, st_reg.count} > ep_size
		|| st_reg.count == 7'h00 || st_reg.eps > uerm_pkg::EPS_MAX;
	assign acc_en = usb_enable;
	assign src_valid = st_reg.src_pend;
	assign src_data = st_reg.dir ? ram_rdata : ep_rdata;
	assign fifo_pop = fifo_out_valid && st_reg.state != uerm_pkg::UERM_IDLE;
	assign fifo_flush = st_reg.state == uerm_pkg::UERM_SETUP;
	uerm_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clk_en(clk_en),
		.flush(fifo_flush),
		.in_valid(src_valid),
		.in_ready(fifo_in_ready),
		.in_data(src_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);
	always_comb
	begin
		st_next = st_reg;
		st_next.ram_rd = 1'b0;
		st_next.ram_wr = 1'b0;
		st_next.ep_rd = 1'b0;
		st_next.ep_wr = 1'b0;
		st_next.security_irq = 1'b0;
		// Source data lands one cycle after the read strobe leaves
		st_next.src_pend = st_reg.ram_rd || st_reg.ep_rd;
		// Sink: each byte leaving the FIFO is written at the destination
		if (fifo_pop)
		begin
			if (st_reg.dir)
			begin
				st_next.ep_wr = 1'b1;
				st_next.ep_ptr = st_reg.wr_ptr;
				st_next.ep_wdata = fifo_out_data;
			end
			else
			begin
				st_next.ram_wr = 1'b1;
				st_next.ram_addr = st_reg.wr_addr;
				st_next.ram_wdata = fifo_out_data;
			end
			st_next.wr_ptr = st_reg.wr_ptr + 8'h01;
			st_next.wr_addr = st_reg.wr_addr + 14'h0001;
		end
		unique case (st_reg.state)
			uerm_pkg::UERM_IDLE:
			begin
				if (acc_en && reg_wr && reg_addr == uerm_pkg::ADDR_CTRL)
				begin
					st_next.eps = reg_wdata[uerm_pkg::EPS_LSB +: 3];
					st_next.dir = reg_wdata[uerm_pkg::BIT_DIR];
					if (!reg_wdata[uerm_pkg::BIT_ERR])
						st_next.err = 1'b0;
					if (reg_wdata[uerm_pkg::BIT_RUN])
					begin
						st_next.run = 1'b1;
						st_next.cpu_stall = 1'b1;
						st_next.irq_hold = 1'b1;
						st_next.state = uerm_pkg::UERM_SETUP;
					end
				end
				if (acc_en && reg_wr && reg_addr == uerm_pkg::ADDR_LOW)
					st_next.addr[7:0] = reg_wdata;
				if (acc_en && reg_wr && reg_addr == uerm_pkg::ADDR_HIGH)
					st_next.addr[13:8] = reg_wdata[5:0];
				if (acc_en && reg_wr && reg_addr == uerm_pkg::ADDR_COUNT)
					st_next.count = reg_wdata[6:0];
			end
			uerm_pkg::UERM_SETUP:
			begin
				// Checks use the values just latched, so a write and launch agree
				if (launch_bad)
				begin
					st_next.err = 1'b1;
					st_next.security_irq = range_bad;
					st_next.run = 1'b0;
					st_next.cpu_stall = 1'b0;
					st_next.irq_hold = 1'b0;
					st_next.state = uerm_pkg::UERM_IDLE;
				end
				else
				begin
					st_next.err = 1'b0;
					st_next.rd_left = st_reg.count;
					st_next.rd_ptr = 8'h00;
					st_next.wr_ptr = 8'h00;
					st_next.move_cyc = 8'h00;
					st_next.wr_addr = st_reg.addr;
					st_next.ram_addr = st_reg.addr;
					st_next.state = uerm_pkg::UERM_MOVE;
				end
			end
			uerm_pkg::UERM_MOVE:
			begin
				// Source read: receive reads the selected endpoint buffer from pointer zero, transmit reads RAM at the address
				if (st_reg.rd_left != 7'h00 && fifo_in_ready)
				begin
					if (st_reg.dir)
					begin
						st_next.ram_rd = 1'b1;
						st_next.ram_addr = st_reg.addr + {7'h00, st_reg.count - st_reg.rd_left};
					end
					else
					begin
						st_next.ep_rd = 1'b1;
						st_next.ep_ptr = st_reg.rd_ptr;
					end
					st_next.rd_ptr = st_reg.rd_ptr + 8'h01;
					st_next.rd_left = st_reg.rd_left - 7'h01;
				end
				st_next.move_cyc = st_reg.move_cyc + 8'h01;
				if (st_reg.rd_left == 7'h00)
					st_next.state = uerm_pkg::UERM_DRAIN;
			end
			uerm_pkg::UERM_DRAIN:
			begin
				if (!st_reg.src_pend && !fifo_out_valid)
				begin
					st_next.addr = st_reg.wr_addr;
					st_next.run = 1'b0;
					st_next.cpu_stall = 1'b0;
					st_next.irq_hold = 1'b0;
					st_next.state = uerm_pkg::UERM_IDLE;
				end
			end
		endcase
		st_next.usb_irq = st_next.err && usb_int_enable && !st_next.irq_hold;
		st_next.rdata = 8'h00;
		if (acc_en && reg_rd)
		begin
			unique case (reg_addr)
				uerm_pkg::ADDR_CTRL: st_next.rdata = {1'b0, st_reg.eps, 1'b0, st_reg.err, st_reg.dir, st_reg.run};
				uerm_pkg::ADDR_LOW: st_next.rdata = st_reg.addr[7:0];
				uerm_pkg::ADDR_HIGH: st_next.rdata = {2'b00, st_reg.addr[13:8]};
				uerm_pkg::ADDR_COUNT: st_next.rdata = {1'b0, st_reg.count};
				default: st_next.rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
			st_reg.addr <= uerm_pkg::ADDR_RESET;
			st_reg.count <= uerm_pkg::COUNT_RESET;
		end
		else if (clk_en)
			st_reg <= st_next;
	end
	assign reg_rdata = st_reg.rdata;
	assign cpu_stall = st_reg.cpu_stall;
	assign irq_hold = st_reg.irq_hold;
	assign usb_irq = st_reg.usb_irq;
	assign security_irq = st_reg.security_irq;
	assign ram_rd = st_reg.ram_rd;
	assign ram_wr = st_reg.ram_wr;
	assign ram_addr = st_reg.ram_addr;
	assign ram_wdata = st_reg.ram_wdata;
	assign ep_rd = st_reg.ep_rd;
	assign ep_wr = st_reg.ep_wr;
	assign ep_sel = st_reg.eps;
	assign ep_ptr = st_reg.ep_ptr;
	assign ep_wdata = st_reg.ep_wdata;
	property p_run_stall;
		@(posedge clk_sys) disable iff (!nrst) st_reg.run |-> st_reg.cpu_stall;
	endproperty
	a_run_stall: assert property (p_run_stall) else $error("run without stall");
	property p_hold;
		@(posedge clk_sys) disable iff (!nrst) st_reg.cpu_stall |-> st_reg.irq_hold && !usb_irq;
	endproperty
	a_hold: assert property (p_hold) else $error("irq during copy");
	property p_high_zero;
		@(posedge clk_sys) disable iff (!nrst) $past(reg_rd && reg_addr == uerm_pkg::ADDR_HIGH) |-> reg_rdata[7:6] == 2'b00;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("address high bits not zero");
	property p_bad_err;
		@(posedge clk_sys) disable iff (!nrst) clk_en && st_reg.state == uerm_pkg::UERM_SETUP && launch_bad |=> st_reg.err && !st_reg.run;
	endproperty
	a_bad_err: assert property (p_bad_err) else $error("bad launch not flagged");
	property p_sec;
		@(posedge clk_sys) disable iff (!nrst) clk_en && st_reg.state == uerm_pkg::UERM_SETUP && range_bad |=> security_irq && $stable(st_reg.addr);
	endproperty
	a_sec: assert property (p_sec) else $error("range error not reported");
	property p_good_clear;
		@(posedge clk_sys) disable iff (!nrst) clk_en && st_reg.state == uerm_pkg::UERM_SETUP && !launch_bad |=> !st_reg.err;
	endproperty
	a_good_clear: assert property (p_good_clear) else $error("good launch kept error");
	property p_count_kept;
		@(posedge clk_sys) disable iff (!nrst) st_reg.state != uerm_pkg::UERM_IDLE |=> $stable(st_reg.count);
	endproperty
	a_count_kept: assert property (p_count_kept) else $error("count changed during copy");
	property p_dir;
		@(posedge clk_sys) disable iff (!nrst) ep_wr |-> st_reg.dir && !ram_wr;
	endproperty
	a_dir: assert property (p_dir) else $error("endpoint written in receive");
	property p_rx_no_readback;
		@(posedge clk_sys) disable iff (!nrst) ep_rd |-> !st_reg.dir;
	endproperty
	a_rx_no_readback: assert property (p_rx_no_readback) else $error("endpoint read in transmit");
	property p_move_len;
		@(posedge clk_sys) disable iff (!nrst) st_reg.state == uerm_pkg::UERM_MOVE |-> st_reg.move_cyc <= {1'b0, st_reg.count};
	endproperty
	a_move_len: assert property (p_move_len) else $error("move phase too long");
	property p_access_stalled;
		@(posedge clk_sys) disable iff (!nrst) ram_rd || ram_wr || ep_rd || ep_wr |-> cpu_stall;
	endproperty
	a_access_stalled: assert property (p_access_stalled) else $error("memory access without stall");
	property p_launch_stall;
		@(posedge clk_sys) disable iff (!nrst) clk_en && st_reg.state == uerm_pkg::UERM_IDLE && acc_en && reg_wr
			&& reg_addr == uerm_pkg::ADDR_CTRL && reg_wdata[uerm_pkg::BIT_RUN] |=> cpu_stall && st_reg.run;
	endproperty
	a_launch_stall: assert property (p_launch_stall) else $error("run bit not taken");
	property p_eps_legal;
		@(posedge clk_sys) disable iff (!nrst) st_reg.state == uerm_pkg::UERM_MOVE |-> st_reg.eps <= uerm_pkg::EPS_MAX && st_reg.count != 7'h00;
	endproperty
	a_eps_legal: assert property (p_eps_legal) else $error("illegal copy started");
	property p_rx_dest;
		@(posedge clk_sys) disable iff (!nrst) ram_wr |-> !st_reg.dir && !ep_wr;
	endproperty
	a_rx_dest: assert property (p_rx_dest) else $error("ram written in transmit");
	property p_end_addr;
		@(posedge clk_sys) disable iff (!nrst) clk_en && st_reg.state == uerm_pkg::UERM_DRAIN && !st_reg.src_pend && !fifo_out_valid
			|=> st_reg.addr == $past(st_reg.addr) + {7'h00, st_reg.count};
	endproperty
	a_end_addr: assert property (p_end_addr) else $error("end address wrong");
	c_launch: cover property (@(posedge clk_sys) disable iff (!nrst) st_reg.state == uerm_pkg::UERM_SETUP && !launch_bad);
	c_bad: cover property (@(posedge clk_sys) disable iff (!nrst) security_irq);
	c_tx_done: cover property (@(posedge clk_sys) disable iff (!nrst) st_reg.dir && $fell(st_reg.run));
	c_rx_done: cover property (@(posedge clk_sys) disable iff (!nrst) !st_reg.dir && st_reg.state == uerm_pkg::UERM_DRAIN ##1 st_reg.state == uerm_pkg::UERM_IDLE);
endmodule : uerm_mover
`default_nettype wire

// ---- design/uerm_pkg.sv ----
package uerm_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'hea;
	localparam logic [7:0] ADDR_LOW = 8'heb;
	localparam logic [7:0] ADDR_HIGH = 8'hec;
	localparam logic [7:0] ADDR_COUNT = 8'hed;
	localparam int BIT_RUN = 0;
	localparam int BIT_DIR = 1;
	localparam int BIT_ERR = 2;
	localparam int EPS_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [13:0] ADDR_RESET = 14'h0100;
	localparam logic [6:0] COUNT_RESET = 7'h00;
	localparam logic [13:0] WIN_LOW = 14'h0100;
	localparam logic [14:0] WIN_END = 15'h10ff;
	localparam logic [7:0] SIZE_EP0 = 8'h40;
	localparam logic [7:0] SIZE_EP13 = 8'h80;
	localparam logic [7:0] SIZE_EP47 = 8'h08;
	localparam logic [2:0] EPS_MAX = 3'h4;
	typedef enum logic [1:0] {
		UERM_IDLE = 2'b00,
		UERM_SETUP = 2'b01,
		UERM_MOVE = 2'b10,
		UERM_DRAIN = 2'b11
	} uerm_state_e;
endpackage : uerm_pkg

// ---- design/uerm_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module uerm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("FIFO depth must be a power of two of at least two");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} uerm_fifo_s;
	uerm_fifo_s st_reg;
	uerm_fifo_s st_next;
	logic push;
	logic pop;
	assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
	assign out_valid = st_reg.cnt != '0;
	assign out_data = st_reg.mem[st_reg.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb
	begin
		st_next = st_reg;
		if (flush)
		begin
			st_next.wr = '0;
			st_next.rd = '0;
			st_next.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				st_next.mem[st_reg.wr] = in_data;
				st_next.wr = st_reg.wr + 1'b1;
			end
			if (pop)
				st_next.rd = st_reg.rd + 1'b1;
			if (push && !pop)
				st_next.cnt = st_reg.cnt + 1'b1;
			else if (pop && !push)
				st_next.cnt = st_reg.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end
endmodule : uerm_fifo
`default_nettype wire

// ---- test/uerm_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// System RAM and endpoint buffers seen by the mover; fixed one-cycle read latency
module uerm_mem_model (
	input wire logic clk_sys,
	input wire logic ram_rd,
	input wire logic ram_wr,
	input wire logic [13:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	output logic [7:0] ram_rdata,
	input wire logic ep_rd,
	input wire logic ep_wr,
	input wire logic [2:0] ep_sel,
	input wire logic [7:0] ep_ptr,
	input wire logic [7:0] ep_wdata,
	output logic [7:0] ep_rdata
);
	logic [7:0] ram_mem [0:16383];
	logic [7:0] ep_mem [0:7][0:255];
	initial ram_rdata = 8'h5a;
	initial ep_rdata = 8'ha5;
	// Data lasts one cycle; a toggling pattern after, so stale bytes never match
	always @(posedge clk_sys)
	begin
		ram_rdata <= ram_rd ? ram_mem[ram_addr] : ~ram_rdata;
		ep_rdata <= ep_rd ? ep_mem[ep_sel][ep_ptr] : ~ep_rdata;
		if (ram_wr)
			ram_mem[ram_addr] <= ram_wdata;
		if (ep_wr)
			ep_mem[ep_sel][ep_ptr] <= ep_wdata;
	end
endmodule : uerm_mem_model
`default_nettype wire

// ---- test/usb_endpoint_ram_dma_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module usb_endpoint_ram_dma_test;
	logic clk_sys = 1'b0, nrst = 1'b0, usb_enable = 1'b1, usb_int_enable = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ram_rdata, ep_rdata, ram_wdata, ep_ptr, ep_wdata, rv;
	logic cpu_stall, irq_hold, usb_irq, security_irq, ram_rd, ram_wr, ep_rd, ep_wr, sec_seen;
	logic [13:0] ram_addr, base;
	logic [2:0] ep_sel, ep;
	logic [6:0] n;
	logic dir;
	logic [7:0] data [0:7];
	int failures = 0, cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		sec_seen <= sec_seen | security_irq;
	uerm_mover u_uerm_mover (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .usb_enable(usb_enable),
		.usb_int_enable(usb_int_enable), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .irq_hold(irq_hold),
		.usb_irq(usb_irq), .security_irq(security_irq), .ram_rd(ram_rd), .ram_wr(ram_wr),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ep_rd(ep_rd), .ep_wr(ep_wr),
		.ep_sel(ep_sel), .ep_ptr(ep_ptr), .ep_wdata(ep_wdata), .ep_rdata(ep_rdata));
	uerm_mem_model u_uerm_mem_model (.clk_sys(clk_sys), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ep_rd(ep_rd), .ep_wr(ep_wr), .ep_sel(ep_sel),
		.ep_ptr(ep_ptr), .ep_wdata(ep_wdata), .ep_rdata(ep_rdata));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge clk_sys);
		#1;
	endtask : rd
	function automatic logic bad(input logic [2:0] e, input logic [13:0] b, input logic [6:0] c);
		logic [7:0] sz;
		sz = (e == 3'h0) ? 8'h40 : (e < 3'h4) ? 8'h80 : 8'h08;
		return c == 7'h00 || e > 3'h4 || {1'b0, c} > sz || b < 14'h0100 || {1'b0, b} + c - 15'h1 > 15'h10ff;
	endfunction : bad
	// Launch one copy and wait for the stall to end
	task automatic launch(input logic set_addr);
		int i;
		wr(8'hed, {1'b0, n});
		if (set_addr)
		begin
			wr(8'heb, base[7:0]);
			wr(8'hec, {2'b00, base[13:8]});
		end
		sec_seen = 1'b0;
		// Flag bit written as one so only the hardware can clear it
		wr(8'hea, {1'b0, ep, 2'b01, dir, 1'b1});
		if (!bad(ep, base, n))
		begin
			`CHK("stall", 1'b1, cpu_stall)
			`CHK("irq_hold", 1'b1, irq_hold)
		end
		i = 0;
		while (cpu_stall !== 1'b0 && i < 300)
		begin
			@(posedge clk_sys);
			#1 i++;
		end
		if (i >= 300)
		begin
			failures++;
			final_report();
		end
		@(posedge clk_sys);
		#1;
		rd(8'hea, rv);
		`CHK("ctrl", {1'b0, ep, 1'b0, bad(ep, base, n), dir, 1'b0}, rv)
		rd(8'hed, rv);
		`CHK("count", {1'b0, n}, rv)
	endtask : launch
	initial
	begin
		void'($urandom(93));
		repeat (16) @(posedge clk_sys);
		#1 nrst = 1'b1;
		rd(8'hea, rv);
		`CHK("ctrl reset", 8'h00, rv)
		rd(8'heb, rv);
		`CHK("low reset", 8'h00, rv)
		clk_en = 1'b0;
		wr(8'heb, 8'h77);
		clk_en = 1'b1;
		rd(8'heb, rv);
		`CHK("frozen write", 8'h00, rv)
		rd(8'hec, rv);
		`CHK("high reset", 8'h01, rv)
		wr(8'hec, 8'hff);
		rd(8'hec, rv);
		`CHK("high upper bits", 8'h3f, rv)
		wr(8'hed, 8'hff);
		rd(8'hed, rv);
		`CHK("count bit 7", 8'h7f, rv)
		$display("test registers done");
		base = 14'h0100 + 14'($urandom_range(0, 200));
		for (int t = 0; t < 8; t++)
		begin
			ep = (t < 5) ? 3'(t) : 3'($urandom_range(0, 4));
			dir = t[0];
			n = (t == 7) ? 7'h08 : 7'($urandom_range(1, 8));
			for (int k = 0; k < n; k++)
			begin
				data[k] = 8'($urandom);
				if (dir)
					u_uerm_mem_model.ram_mem[base + 14'(k)] = data[k];
				else
					u_uerm_mem_model.ep_mem[ep][k] = data[k];
			end
			launch(t == 0);
			for (int k = 0; k < n; k++)
				if (dir)
					`CHK("ep byte", data[k], u_uerm_mem_model.ep_mem[ep][k])
				else
					`CHK("ram byte", data[k], u_uerm_mem_model.ram_mem[base + 14'(k)])
			base = base + 14'(n);
			rd(8'heb, rv);
			`CHK("addr low", base[7:0], rv)
			rd(8'hec, rv);
			`CHK("addr high", {2'b00, base[13:8]}, rv)
		end
		$display("test copies done");
		for (int t = 0; t < 6; t++)
		begin
			ep = (t == 1) ? 3'h5 : (t == 2) ? 3'h4 : (t == 5) ? 3'h7 : 3'h0;
			base = (t == 3) ? 14'h10fc : (t == 4) ? 14'h00ff : 14'h0100;
			n = (t == 0) ? 7'h00 : (t == 2) ? 7'h09 : (t == 3) ? 7'h05 : 7'h01;
			dir = 1'b1;
			launch(1'b1);
			`CHK("usb irq", 1'b1, usb_irq)
			usb_int_enable = 1'b0;
			@(posedge clk_sys);
			#1 usb_int_enable = 1'b1;
			`CHK("usb irq masked", 1'b0, usb_irq)
			`CHK("security irq", (t == 3 || t == 4) ? 1'b1 : 1'b0, sec_seen)
			rd(8'heb, rv);
			`CHK("addr kept", base[7:0], rv)
			wr(8'hea, {1'b0, ep, 4'h0});
			rd(8'hea, rv);
			`CHK("err cleared", {1'b0, ep, 4'h0}, rv)
			`CHK("usb irq off", 1'b0, usb_irq)
		end
		ep = 3'h0;
		base = 14'h0100;
		n = 7'h00;
		dir = 1'b0;
		launch(1'b1);
		n = 7'h01;
		launch(1'b0);
		base = base + 14'(n);
		$display("test errors done");
		usb_enable = 1'b0;
		wr(8'heb, 8'h55);
		rd(8'heb, rv);
		`CHK("disabled read", 8'h00, rv)
		usb_enable = 1'b1;
		rd(8'heb, rv);
		`CHK("disabled write", base[7:0], rv)
		$display("test disable done");
		final_report();
	end
endmodule : usb_endpoint_ram_dma_test
`default_nettype wire
